/* common/p0io_defines.vh */
// Constants for the port 0 I/O block: offsets, field positions, reset values
// What this block does
// (RULE1) Each pin has an output latch written via data register, drives pin when output.
// (RULE2) Each pin's direction set independently by its own direction register bit.
// (RULE3) Pull-up active only for input-mode pins whose pull-up select bit is set.
// (RULE4) Pins carry timer I/O, external interrupt inputs and serial chip-select input.
// (RULE5) Alt switch register routes extra timer input/output onto first pin only.
// (RULE6) Any reset sets every direction bit to input.
// (RULE7) Software clears direction bit 1 after reset on the small package variant.
// (RULE8) Data read returns pin level for inputs, latch contents for outputs.
`ifndef P0IO_DEFINES_VH
`define P0IO_DEFINES_VH

// ==========================================================================
// Register byte offsets on APB
`define P0IO_OFS_DATA 12'h000
`define P0IO_OFS_DIR 12'h004
`define P0IO_OFS_PULLUP 12'h008
`define P0IO_OFS_ALTSW 12'h00c

// ==========================================================================
// Widths and reset values
`define P0IO_NPINS 3
`define P0IO_DIR_RST 3'h7
`define P0IO_DATA_RST 3'h0
`define P0IO_PULLUP_RST 3'h0
`define P0IO_ALTSW_RST 2'h0

// ==========================================================================
// Alt switch fields
`define P0IO_ALTSW_TOUT_BIT 0
`define P0IO_ALTSW_TIN_BIT 1

// ==========================================================================
// Pin indices
`define P0IO_PIN_FIRST 0
`define P0IO_PIN_SECOND 1
`define P0IO_PIN_THIRD 2

`endif

/* design/p0io_sync.v */
// Two-flop synchroniser for the port pin inputs
`timescale 1ns/100ps
module p0io_sync (
  input wire pclk,
  input wire presetn,
  input wire [2:0] d,
  output reg [2:0] q
);
  reg [2:0] meta_q;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= 3'h0;
      q <= 3'h0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule

/* design/p0io_port.v */
// Port 0 three-pin GPIO with pull-ups, alternate functions and APB registers
`timescale 1ns/100ps
`include "p0io_defines.vh"
module p0io_port (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [2:0] pin_in,
  output reg [2:0] pin_out,
  output reg [2:0] pin_oe,
  output reg [2:0] pin_pullup_en,
  input wire timer_wave_out,
  input wire timer_h_out,
  input wire [2:0] alt_out_en,
  output reg timer_capture_in_a,
  output reg timer_capture_in_b,
  output reg ext_irq_in_a,
  output reg ext_irq_in_b,
  output reg serial_select_in,
  output reg timer_eight_bit_in
);

  // ========================================================================
  // Registers
  reg [2:0] port_data_reg_q;
  reg [2:0] port_direction_reg_q;
  reg [2:0] pullup_select_reg_q;
  reg [1:0] alt_function_switch_reg_q;
  wire [2:0] pin_sync;

  // ========================================================================
  // Pin input synchroniser
  // Pins change with no regard to pclk, so only the second flop is ever read
  p0io_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d(pin_in),
    .q(pin_sync)
  );

  // ========================================================================
  // Address decode
  // One-hot register select: data, direction, pull-up, alt switch
  function [3:0] reg_onehot;
    input [11:0] a;
    begin
      reg_onehot = 4'h0;
      case (a)
        `P0IO_OFS_DATA: reg_onehot = 4'h1;
        `P0IO_OFS_DIR: reg_onehot = 4'h2;
        `P0IO_OFS_PULLUP: reg_onehot = 4'h4;
        `P0IO_OFS_ALTSW: reg_onehot = 4'h8;
        default: reg_onehot = 4'h0;
      endcase
    end
  endfunction

  function mapped;
    input [11:0] a;
    begin
      mapped = |reg_onehot(a);
    end
  endfunction

  // Inputs show the synchronised pin, outputs the latch
  function [2:0] pin_view;
    input [2:0] dir;
    input [2:0] pin;
    input [2:0] latch;
    begin
      pin_view = (dir & pin) | (~dir & latch);
    end
  endfunction

  // ========================================================================
  // APB slave: zero wait states, error on unmapped address
  wire setup_ph;
  wire acc;
  wire wr;
  wire [3:0] hit;
  wire [3:0] wr_sel;
  reg [31:0] rd_d;

  assign setup_ph = psel && !penable;
  assign acc = psel && penable;
  assign hit = reg_onehot(paddr);
  // Only byte lane 0 holds register bits, so the other strobes are ignored
  assign wr = acc && pwrite && pstrb[0] && mapped(paddr);
  assign wr_sel = wr ? hit : 4'h0;

  always @* begin
    rd_d = 32'h0;
    case (hit)
      4'h1: rd_d[2:0] = pin_view(port_direction_reg_q, pin_sync, port_data_reg_q); // RULE8
      4'h2: rd_d[2:0] = port_direction_reg_q;
      4'h4: rd_d[2:0] = pullup_select_reg_q;
      4'h8: rd_d[1:0] = alt_function_switch_reg_q;
      default: rd_d = 32'h0;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      // The answer always follows the setup edge by one cycle
      pready <= setup_ph;
      pslverr <= setup_ph && !mapped(paddr);
      // Captured at the setup edge: a read shows the registers of that moment
      if (setup_ph && !pwrite) begin
        prdata <= rd_d;
      end
    end
  end

  // ========================================================================
  // Output latch
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_data_reg_q <= `P0IO_DATA_RST;
    end else begin
      if (wr_sel[0]) begin
        port_data_reg_q <= pwdata[2:0]; // RULE1
      end
    end
  end

  // ========================================================================
  // Direction register; a set bit makes the pin an input
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_direction_reg_q <= `P0IO_DIR_RST; // RULE6
    end else begin
      if (wr_sel[1]) begin
        // Software must clear bit 1 after reset on the small package
        port_direction_reg_q <= pwdata[2:0]; // RULE2
      end
    end
  end

  // ========================================================================
  // Pull-up select register
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pullup_select_reg_q <= `P0IO_PULLUP_RST;
    end else begin
      if (wr_sel[2]) begin
        pullup_select_reg_q <= pwdata[2:0]; // RULE3
      end
    end
  end

  // ========================================================================
  // Alternate-function switch register
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alt_function_switch_reg_q <= `P0IO_ALTSW_RST;
    end else begin
      if (wr_sel[3]) begin
        alt_function_switch_reg_q <= pwdata[1:0]; // RULE5
      end
    end
  end

  // ========================================================================
  // Pin drive
  reg [2:0] out_d;
  reg [2:0] oe_d;
  reg [2:0] pull_d;
  reg tin_d;

  always @* begin
    out_d = port_data_reg_q; // RULE1
    oe_d = ~port_direction_reg_q; // RULE2
    // No pull-up while the pin drives, whatever the select bit says
    pull_d = port_direction_reg_q & pullup_select_reg_q; // RULE3
    tin_d = pin_sync[`P0IO_PIN_FIRST] &
            alt_function_switch_reg_q[`P0IO_ALTSW_TIN_BIT]; // RULE5
    // Alternate outputs replace the latch; they reach the pin only in output mode
    if (alt_out_en[`P0IO_PIN_SECOND]) begin
      out_d[`P0IO_PIN_SECOND] = timer_wave_out; // RULE4
    end
    if (alt_out_en[`P0IO_PIN_FIRST] && alt_function_switch_reg_q[`P0IO_ALTSW_TOUT_BIT]) begin
      out_d[`P0IO_PIN_FIRST] = timer_h_out; // RULE5
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out <= 3'h0;
      pin_oe <= 3'h0;
      pin_pullup_en <= 3'h0;
    end else begin
      pin_out <= out_d;
      pin_oe <= oe_d;
      pin_pullup_en <= pull_d;
    end
  end

  // ========================================================================
  // Alternate inputs
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_capture_in_a <= 1'b0;
      timer_capture_in_b <= 1'b0;
      ext_irq_in_a <= 1'b0;
      ext_irq_in_b <= 1'b0;
      serial_select_in <= 1'b0;
      timer_eight_bit_in <= 1'b0;
    end else begin
      // Alternate inputs see the synchronised pin level; timer_eight_bit_in only while the alt switch input bit is set
      timer_capture_in_a <= pin_sync[`P0IO_PIN_FIRST]; // RULE4
      ext_irq_in_a <= pin_sync[`P0IO_PIN_FIRST];
      timer_capture_in_b <= pin_sync[`P0IO_PIN_SECOND];
      serial_select_in <= pin_sync[`P0IO_PIN_THIRD];
      ext_irq_in_b <= pin_sync[`P0IO_PIN_THIRD];
      timer_eight_bit_in <= tin_d; // RULE5
    end
  end
endmodule

/* verif/p0io_monitor.sv */
// Port 0 checker
`timescale 1ns/100ps
module p0io_monitor(
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pready,
  input wire pslverr,
  input wire [2:0] pin_oe,
  input wire [2:0] pin_pullup_en,
  input wire timer_capture_in_a,
  input wire ext_irq_in_a,
  input wire ext_irq_in_b,
  input wire serial_select_in,
  input wire timer_eight_bit_in
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_zero: assert property (psel && !penable |=> pready) else $error("late");
  a_ready_once: assert property (pready |=> !pready) else $error("long");
  a_err_pair: assert property (pslverr |-> pready) else $error("err");
  a_pull_input: assert property ((pin_pullup_en & pin_oe) == 3'h0) else $error("pu");
  a_dir_reset: assert property ($rose(presetn) |-> pin_oe == 3'h0) else $error("oe");
  a_irq_pin: assert property (ext_irq_in_a == timer_capture_in_a) else $error("irq");
  a_sel_pin: assert property (serial_select_in == ext_irq_in_b) else $error("sel");
  a_eight_gate: assert property (timer_eight_bit_in |-> timer_capture_in_a) else $error("t");
  // No bus traffic for two edges leaves the direction untouched
  a_oe_hold: assert property (!psel ##1 !psel |=> $stable(pin_oe)) else $error("dir");
  cover property (pslverr);
  cover property (pin_pullup_en != 3'h0);
  cover property (timer_eight_bit_in);
endmodule
bind p0io_port p0io_monitor i_p0io_monitor(.*);

/* verif/p0io_board.sv */
// Board model for the port 0 pins
`timescale 1ns/100ps
module p0io_board(
  input wire pclk,
  input wire [2:0] pin_out,
  input wire [2:0] pin_oe,
  input wire [2:0] pin_pullup_en,
  input wire [2:0] ext_en,
  input wire [2:0] ext_val,
  output logic [2:0] pin_in
);
  logic [2:0] flt_q = 3'h0;
  // Undriven pins without pull-up toggle so a stale level never passes
  always @(posedge pclk) flt_q <= ~flt_q;
  always_comb
    for (int i = 0; i < 3; i++)
      pin_in[i] = pin_oe[i] ? pin_out[i] : ext_en[i] ? ext_val[i] : pin_pullup_en[i] | flt_q[i];
endmodule

/* verif/p0io_port_tb_top.sv */
// Port 0 testbench
`timescale 1ns/100ps
module p0io_port_tb_top;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
  logic timer_wave_out = 0, timer_h_out = 0, timer_capture_in_a, timer_capture_in_b;
  logic ext_irq_in_a, ext_irq_in_b, serial_select_in, timer_eight_bit_in;
  logic [11:0] paddr = 12'h0;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [2:0] pin_in, pin_out, pin_oe, pin_pullup_en, alt_out_en = 0, ext_en = 0, ext_val = 0;
  int bad_count = 0, checked = 0;
  p0io_port i_p0io_port(.*);
  p0io_board i_p0io_board(.*);
  initial forever #5 pclk = ~pclk;
  task chk(input [31:0] seen, input [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %h expected %h", $time, seen, exp);
    end
  endtask
  task xfer(input w, input [11:0] a, input [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task finish_test;
    $display("checked %0d bad %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // ====
  // Sequence
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    xfer(0, 12'h004, 0);
    chk(rd, 32'h7);
    xfer(1, 12'h004, 32'h5);
    xfer(1, 12'h000, 32'h6);
    xfer(1, 12'h008, 32'h7);
    ext_en <= 3'h5;
    repeat (4) @(posedge pclk);
    chk(pin_oe, 32'h2);
    chk(pin_out, 32'h6);
    chk(pin_pullup_en, 32'h5);
    xfer(0, 12'h000, 0);
    chk(rd, 32'h2);
    ext_val <= 3'h4;
    repeat (4) @(posedge pclk);
    chk({timer_capture_in_a, timer_capture_in_b, serial_select_in}, 32'h3);
    chk({ext_irq_in_a, ext_irq_in_b}, 32'h1);
    ext_en <= 3'h0;
    repeat (4) @(posedge pclk);
    chk({timer_capture_in_a, timer_eight_bit_in}, 32'h2);
    xfer(1, 12'h00c, 32'h3);
    repeat (4) @(posedge pclk);
    chk(timer_eight_bit_in, 32'h1);
    xfer(0, 12'h000, 0);
    chk(rd, 32'h7);
    $display("test pins done");
    timer_h_out <= 1;
    alt_out_en <= 3'h3;
    xfer(1, 12'h004, 32'h4);
    repeat (4) @(posedge pclk);
    chk(pin_out[1:0], 32'h1);
    xfer(1, 12'h00c, 32'h2);
    repeat (2) @(posedge pclk);
    chk(pin_out[1:0], 32'h0);
    pstrb <= 4'he;
    xfer(1, 12'h000, 32'h0);
    pstrb <= 4'hf;
    xfer(0, 12'h000, 0);
    chk(rd, 32'h6);
    xfer(0, 12'h010, 0);
    chk({er, rd[2:0]}, 32'h8);
    presetn <= 0;
    @(posedge pclk);
    chk(pin_oe, 32'h0);
    presetn <= 1;
    @(posedge pclk);
    xfer(0, 12'h004, 0);
    chk(rd, 32'h7);
    $display("test alt and reset done");
    finish_test;
  end
  initial begin
    repeat (3000) @(posedge pclk);
    bad_count++;
    finish_test;
  end
endmodule
